//--- hdl/sram_host_pkg.sv
// Package with pin bundles, states and timing counts for the static memory host.
package sram_host_pkg;

	// Memory geometry.
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;

	// Clock period in picoseconds (25 MHz).
	localparam int CLK_PS = 40000;

	// Device timing in nanoseconds, slower speed grade so both grades work.
	localparam int READ_CYCLE_NS              = 200;
	localparam int ADDRESS_ACCESS_TIME_NS     = 200;
	localparam int WRITE_PULSE_NS             = 140;
	localparam int WRITE_RECOVERY_NS          = 35;
	localparam int WRITE_TO_FLOAT_TIME_NS     = 60;
	localparam int DESELECT_TO_FLOAT_TIME_NS  = 60;
	localparam int RETENTION_RECOVERY_TIME_NS = 200;

	// Least times round up to whole cycles; floats are waits, so round up too.
	localparam int READ_CYC  = (READ_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int ACC_CYC   =
		(ADDRESS_ACCESS_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WP_CYC    = (WRITE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC    =
		(WRITE_RECOVERY_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int FLOAT_CYC =
		(DESELECT_TO_FLOAT_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int RDR_CYC   =
		(RETENTION_RECOVERY_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;

	localparam logic [7:0] CNT_ZERO = 8'h00;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_READ  = 3'b001,
		ST_WSET  = 3'b010,
		ST_WPUL  = 3'b011,
		ST_WREC  = 3'b100,
		ST_FLOAT = 3'b101,
		ST_HOLD  = 3'b110
	} state_e;

	// Control pins toward the memory, all active low.
	typedef struct packed {
		logic sel_n;
		logic gate_n;
		logic wr_n;
	} ctrl_s;

	localparam ctrl_s CTRL_IDLE = 3'b111;
endpackage

//--- hdl/sram_host.sv
// Host controller that runs reads and writes on a 2K by 8 static memory.
// What this block does
// - Address is held for the write recovery time after write strobe rises.
// - The host never drives the data lines while the memory may drive them.
// - Host data is applied only once the memory outputs are known to float.
// - Retention seen in idle keeps select high; the next access then waits a read cycle.

// Timing notes for whoever retunes the clock or the memory grade.
// Every interval is a whole number of clocks, rounded up from the slower
// speed grade so that either grade of memory works without changes.
// A read drives address, select and gate on the take edge, keeps them for
// five cycles, samples the data on the last one and then idles two cycles
// so the memory has released the data lines before the next access.
// A write sets address and data on the take edge, lowers select and strobe
// together two cycles later, holds them four cycles and keeps address and
// data one cycle more for recovery; gate stays high throughout.
// The host drives the data lines only from the strobe fall until one cycle
// after it rises, so the two sides never fight over the bus.
// Requests seen while busy or in retention are ignored, not refused: the
// requester keeps valid up until an edge sees ready high.
// Retention only keeps select high once the sequencer is idle; supply handling lives outside this block.
module sram_host
	import sram_host_pkg::*;
(
	input  wire logic              CLOCK,
	input  wire logic              RST_B,
	input  wire logic              REQ_VALID,
	input  wire logic              REQ_WRITE,
	input  wire logic [ADDR_W-1:0] REQ_ADDR,
	input  wire logic [DATA_W-1:0] REQ_WDATA,
	input  wire logic              RETAIN,
	output logic                   REQ_READY,
	output logic                   RSP_VALID,
	output logic      [DATA_W-1:0] RSP_RDATA,
	output logic      [ADDR_W-1:0] MEM_ADDR,
	output logic                   MEM_SEL_N,
	output logic                   MEM_GATE_N,
	output logic                   MEM_WR_N,
	output logic      [DATA_W-1:0] MEM_DQ_OUT,
	output logic                   MEM_DQ_OE_N,
	input  wire logic [DATA_W-1:0] MEM_DQ_IN
);

	// Registered state, down-counter and every value that reaches a pin.
	state_e            state_reg, state_next;
	logic [7:0]        cnt_reg, cnt_next;
	ctrl_s             ctrl_reg, ctrl_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic              oe_n_reg, oe_n_next;
	logic              rvalid_reg, rvalid_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic              ready_reg, ready_next;

	// Pin patterns for the two kinds of access.
	localparam ctrl_s CTRL_READ  = '{sel_n: 1'b0, gate_n: 1'b0, wr_n: 1'b1};
	localparam ctrl_s CTRL_WRITE = '{sel_n: 1'b0, gate_n: 1'b1, wr_n: 1'b0};

	// Counter loads, cut to the counter width on purpose; all fit in 8 bits.
	wire [7:0] acc_load   = 8'(ACC_CYC);
	wire [7:0] pulse_load = 8'(WP_CYC);
	wire [7:0] rec_load   = 8'(WR_CYC);
	wire [7:0] float_load = 8'(FLOAT_CYC);
	wire [7:0] rdr_load   = 8'(RDR_CYC);

	// Counter decode and the request handshake.
	wire cnt_done = (cnt_reg == CNT_ZERO);
	wire cnt_last = (cnt_reg == 8'h01);
	// A request is taken only on an edge that sees ready, and never in retention.
	wire take     = ready_reg && REQ_VALID && !RETAIN;
	wire [7:0] cnt_dec = cnt_reg - 8'h01;

	// Next-state sequencing; every pin change is a registered step.
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_done ? CNT_ZERO : cnt_dec;
		ctrl_next   = ctrl_reg;
		addr_next   = addr_reg;
		wdata_next  = wdata_reg;
		oe_n_next   = oe_n_reg;
		rvalid_next = 1'b0;
		rdata_next  = rdata_reg;
		ready_next  = 1'b0;
		case (state_reg)
			// Idle: memory deselected, ready offered unless in retention.
			ST_IDLE: begin
				ctrl_next = CTRL_IDLE;
				oe_n_next = 1'b1;
				ready_next = !RETAIN && !take;
				if (RETAIN) begin
					// Coming out of retention must wait a full read cycle.
					state_next = ST_HOLD;
					cnt_next   = rdr_load;
				end else if (take) begin
					addr_next  = REQ_ADDR;
					wdata_next = REQ_WDATA;
					if (REQ_WRITE) begin
						// Address settles before select and strobe fall.
						state_next = ST_WSET;
						cnt_next   = 8'h01;
					end else begin
						// Address, select and gate all move on the same edge.
						ctrl_next  = CTRL_READ;
						state_next = ST_READ;
						cnt_next   = acc_load;
					end
				end
			end
			// Read: data is taken on the last access cycle, then deselect.
			ST_READ: begin
				if (cnt_last) begin
					rdata_next  = MEM_DQ_IN;
					rvalid_next = 1'b1;
					ctrl_next   = CTRL_IDLE;
					state_next  = ST_FLOAT;
					cnt_next    = float_load;
				end
			end
			// Write setup: the address has stood since the take edge.
			ST_WSET: begin
				if (cnt_done) begin
					// Select and strobe fall together, gate kept high.
					ctrl_next  = CTRL_WRITE;
					oe_n_next  = 1'b0;
					state_next = ST_WPUL;
					cnt_next   = pulse_load;
				end
			end
			// Write pulse: both strobes low for the full pulse width.
			ST_WPUL: begin
				if (cnt_last) begin
					ctrl_next  = CTRL_IDLE;
					state_next = ST_WREC;
					cnt_next   = rec_load;
				end
			end
			// Write recovery: the host still drives the data lines here.
			ST_WREC: begin
				// Address and data stay put through recovery.
				if (cnt_last) begin
					oe_n_next  = 1'b1;
					state_next = ST_IDLE;
					ready_next = !RETAIN;
				end
			end
			// Float: idle cycles so the memory outputs are off the bus.
			ST_FLOAT: begin
				if (cnt_last) begin
					state_next = ST_IDLE;
					ready_next = !RETAIN;
				end
			end
			// Hold: the recovery wait restarts while retention is held.
			ST_HOLD: begin
				ctrl_next = CTRL_IDLE;
				if (RETAIN) begin
					cnt_next = rdr_load;
				end else if (cnt_last) begin
					state_next = ST_IDLE;
					ready_next = 1'b1;
				end
			end
			// Unused codes fall back to a safe idle with the bus released.
			default: begin
				state_next = ST_IDLE;
				ctrl_next  = CTRL_IDLE;
				oe_n_next  = 1'b1;
			end
		endcase
	end

	// State and pin registers; reset leaves the memory deselected.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			// Reset parks every memory pin at its idle level; ready starts low.
			state_reg  <= ST_IDLE;
			cnt_reg    <= CNT_ZERO;
			ctrl_reg   <= CTRL_IDLE;
			addr_reg   <= '0;
			wdata_reg  <= '0;
			oe_n_reg   <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			ready_reg  <= 1'b0;
		end else begin
			// Every register moves on every edge; there is no enable.
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			ctrl_reg   <= ctrl_next;
			addr_reg   <= addr_next;
			wdata_reg  <= wdata_next;
			oe_n_reg   <= oe_n_next;
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			ready_reg  <= ready_next;
		end
	end

	// Pins come straight from the registers above.
	assign REQ_READY   = ready_reg;
	assign RSP_VALID   = rvalid_reg;
	assign RSP_RDATA   = rdata_reg;
	assign MEM_ADDR    = addr_reg;
	assign MEM_SEL_N   = ctrl_reg.sel_n;
	assign MEM_GATE_N  = ctrl_reg.gate_n;
	assign MEM_WR_N    = ctrl_reg.wr_n;
	// The data-line enable is active low: low while the host drives.
	assign MEM_DQ_OUT  = wdata_reg;
	assign MEM_DQ_OE_N = oe_n_reg;

endmodule

//--- tb/sram_host_props.sv
// Pin timing checks for the static memory host, bound into the design.
module sram_host_props
	import sram_host_pkg::*;
(
	input wire logic              CLOCK,
	input wire logic              RST_B,
	input wire logic              RETAIN,
	input wire logic [ADDR_W-1:0] MEM_ADDR,
	input wire logic              MEM_SEL_N,
	input wire logic              MEM_GATE_N,
	input wire logic              MEM_WR_N,
	input wire logic              MEM_DQ_OE_N
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	// Steps of a read: address held with gate low, then a float gap.
	sequence s_access;
		(!MEM_GATE_N && $stable(MEM_ADDR)) [*4];
	endsequence
	sequence s_float;
		MEM_SEL_N [*2];
	endsequence
	AST_READ_PINS: assert property (!MEM_GATE_N |-> MEM_WR_N && !MEM_SEL_N)
		else $error("gate low outside a read");
	AST_NO_FIGHT: assert property (!MEM_GATE_N |-> MEM_DQ_OE_N)
		else $error("host drives data during a read");
	AST_WR_PINS: assert property (!MEM_WR_N |-> MEM_GATE_N && !MEM_DQ_OE_N)
		else $error("write strobe without host data");
	AST_WR_SEL: assert property ($fell(MEM_WR_N) |-> $fell(MEM_SEL_N))
		else $error("select and strobe fell apart");
	AST_WR_HOLD: assert property ($rose(MEM_WR_N) |=> $stable(MEM_ADDR))
		else $error("address moved in write recovery");
	AST_ACCESS: assert property ($fell(MEM_SEL_N) && MEM_WR_N |=> s_access)
		else $error("read cut short");
	AST_FLOAT: assert property ($rose(MEM_SEL_N) |-> s_float)
		else $error("no float gap after deselect");
	AST_RETAIN: assert property ($fell(RETAIN) |-> MEM_SEL_N [*5])
		else $error("access too soon after retention");
endmodule
bind sram_host sram_host_props props_u (.CLOCK(CLOCK), .RST_B(RST_B),
	.RETAIN(RETAIN), .MEM_ADDR(MEM_ADDR), .MEM_SEL_N(MEM_SEL_N),
	.MEM_GATE_N(MEM_GATE_N), .MEM_WR_N(MEM_WR_N),
	.MEM_DQ_OE_N(MEM_DQ_OE_N));

//--- tb/sram_mem_model.sv
// Behavioural 2K by 8 static memory on the controller's pins.
module sram_mem_model
	import sram_host_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              sel_n,
	input  wire logic              gate_n,
	input  wire logic              wr_n,
	input  wire logic [DATA_W-1:0] din,
	input  wire logic              oe_n,
	output logic      [DATA_W-1:0] dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] last_q = 8'h00;
	wire drive = !sel_n && !gate_n && wr_n;
	// Sampling on the clock is enough, as the host holds pins for cycles.
	always @(posedge clk) begin
		if (!sel_n && !wr_n) mem[addr] <= din;
		if (drive) last_q <= mem[addr];
	end
	// Released lines show the inverse of the last word, so no stale match.
	assign dout = !oe_n ? din : drive ? mem[addr] : ~last_q;
endmodule

//--- tb/sram_host_test.sv
// Self-checking bench for the static memory host controller.
module sram_host_test
	import sram_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst_b = 0, valid = 0, write = 0, retain = 0;
	logic [ADDR_W-1:0] addr = 11'h000, maddr;
	logic [DATA_W-1:0] wdata = 8'h00, rdata, dq_o, dq_i;
	logic ready, rsp_valid, sel_n, gate_n, wr_n, oe_n;
	int err_total = 0, tests_run = 0, cycles = 0;
	sram_host dut_u (.CLOCK(clock), .RST_B(rst_b), .REQ_VALID(valid),
		.REQ_WRITE(write), .REQ_ADDR(addr), .REQ_WDATA(wdata),
		.RETAIN(retain), .REQ_READY(ready), .RSP_VALID(rsp_valid),
		.RSP_RDATA(rdata), .MEM_ADDR(maddr), .MEM_SEL_N(sel_n),
		.MEM_GATE_N(gate_n), .MEM_WR_N(wr_n), .MEM_DQ_OUT(dq_o),
		.MEM_DQ_OE_N(oe_n), .MEM_DQ_IN(dq_i));
	sram_mem_model mem_u (.clk(clock), .addr(maddr), .sel_n(sel_n),
		.gate_n(gate_n), .wr_n(wr_n), .din(dq_o), .oe_n(oe_n), .dout(dq_i));
	// Clock of 40 ns and a cycle ceiling that cuts a hang short.
	initial forever #20 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			complete_run;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Holds the request until an edge sees ready, then drops it.
	task automatic issue(input logic w, input logic [10:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clock);
		#1 valid = 1;
		write = w;
		addr = a;
		wdata = d;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (ready !== 1'b1 && n < 50);
		check({7'h00, ready}, 8'h01);
		@(posedge clock);
		#1 valid = 0;
	endtask
	task automatic read_chk(input logic [10:0] a, input logic [7:0] exp);
		int n;
		issue(1'b0, a, 8'h00);
		for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge clock);
		check({7'h00, rsp_valid}, 8'h01);
		check(8'(n), 8'(ACC_CYC + 1));
		check(rdata, exp);
	endtask
	// Back-to-back writes at both ends of the range, then readback.
	task automatic t_rw;
		issue(1'b1, 11'h000, 8'hA5);
		issue(1'b1, 11'h7FF, 8'h3C);
		issue(1'b1, 11'h2AA, 8'h5A);
		read_chk(11'h000, 8'hA5);
		read_chk(11'h7FF, 8'h3C);
		read_chk(11'h2AA, 8'h5A);
		$display("test rw done");
	endtask
	// A write offered during retention must be ignored.
	task automatic t_retain;
		@(posedge clock);
		#1 retain = 1;
		valid = 1;
		write = 1;
		wdata = 8'hFF;
		addr = 11'h000;
		repeat (2) @(negedge clock);
		repeat (6) begin
			@(negedge clock);
			check({6'h00, ready, sel_n}, 8'h01);
		end
		@(posedge clock);
		#1 retain = 0;
		valid = 0;
		read_chk(11'h000, 8'hA5);
		$display("test retain done");
	endtask
	task automatic complete_run;
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		#1 rst_b = 1;
		t_rw;
		t_retain;
		complete_run;
	end
endmodule
